// file: hw/pld_map.vh
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 100 MHz system clock
// Notes: Definitions only
`ifndef PLD_MAP_VH
`define PLD_MAP_VH
`define PLD_CLK_MHZ 100
// Register offsets on the management bus
`define PLD_OFF_BASIC 5'h00
`define PLD_OFF_STATUS 5'h10
`define PLD_OFF_IND 5'h18
`define PLD_OFF_PHYCTL 5'h19
`define PLD_OFF_DIAG 5'h1B
// Basic control fields
`define PLD_BC_LOOP 14
`define PLD_BC_SPEED 13
`define PLD_BC_ANEN 12
`define PLD_BC_ISO 10
`define PLD_BC_DUPLEX 8
`define PLD_BC_RESET 16'h1000
// Phy status fields
`define PLD_ST_LINK 0
`define PLD_ST_SPEED10 1
`define PLD_ST_DUPLEX 2
`define PLD_ST_LOOP 3
// Phy control fields
`define PLD_PC_ADDR_HI 4
`define PLD_PC_CFG0 5
`define PLD_PC_CFG1 6
`define PLD_PC_BSTAT 8
`define PLD_PC_BSTART 9
`define PLD_PC_PRBS15 10
// Diagnostic control fields
`define PLD_DG_CONT 5
`define PLD_DG_ERR_LO 8
// Indicator override fields: enables [2:0], values [5:3]
`define PLD_IO_EN_LO 0
`define PLD_IO_VAL_LO 3
// Strap pull values when a pin floats
`define PLD_ADDR_PULL 5'h01
// Link detection, indicator blink half-period and self-test packet length
`define PLD_NLP_MIN 3'h7
`define PLD_LINK_LOSS_MS 50
`define PLD_BLINK_MS 50
`define PLD_SELF_TEST_ENGINE_PKT 16'h0100
`endif

// file: hw/pld_prbs.v
// Purpose: Pseudo-random nibble generator and checker for the self-test
// Assumes: One nibble per advance, bit 0 sent first
// Notes: Checker is self-synchronising from the received stream
`timescale 1ns/10ps
`default_nettype none
module pld_prbs (
  input wire clk,
  input wire rst_b,
  input wire len15,
  input wire clear,
  input wire gen_adv,
  input wire chk_valid,
  input wire [3:0] chk_data,
  output reg [3:0] gen_data,
  output reg good,
  output reg err
);
  reg [14:0] gen_q;
  reg [14:0] rx_q;
  reg [4:0] fill_q;
  reg [14:0] g;
  reg [14:0] r;
  reg [3:0] nib;
  reg bad;
  integer i;

  ////////////////////////////////////////////////////////////////
  // Four steps per nibble; taps select 9 or 15 bit sequence
  always @* begin
    g = gen_q;
    r = rx_q;
    nib = 4'h0;
    bad = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      nib[i] = len15 ? (g[14] ^ g[13]) : (g[8] ^ g[4]);
      g = {g[13:0], nib[i]};
      if ((len15 ? (r[14] ^ r[13]) : (r[8] ^ r[4])) != chk_data[i])
        bad = 1'b1;
      r = {r[13:0], chk_data[i]};
    end
  end

  // The first nibble after a clear is the generator's stale output, so the
  // checker takes five nibbles before comparing; 15-bit mode needs all of them
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gen_q <= 15'h7FFF;
      rx_q <= 15'h0000;
      fill_q <= 5'h00;
      gen_data <= 4'h0;
      good <= 1'b0;
      err <= 1'b0;
    end else begin
      good <= 1'b0;
      err <= 1'b0;
      if (clear) begin
        gen_q <= 15'h7FFF;
        fill_q <= 5'h00;
      end else begin
        if (gen_adv) begin
          gen_q <= g;
          gen_data <= nib;
        end
        if (chk_valid) begin
          rx_q <= r;
          if (fill_q < 5'h14)
            fill_q <= fill_q + 5'h04;
          else begin
            good <= ~bad;
            err <= bad;
          end
        end
      end
    end
  end
endmodule // pld_prbs
`default_nettype wire

// file: hw/pld_ind.v
// Purpose: One indicator output with override and strap-set polarity
// Assumes: Polarity strap captured by the caller
// Notes: Output is registered
`timescale 1ns/10ps
`default_nettype none
module pld_ind (
  input wire clk,
  input wire rst_b,
  input wire on,
  input wire ovr_en,
  input wire ovr_val,
  input wire strap_high,
  output reg pin
);
  // Strap high means active low drive
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      pin <= 1'b0;
    else
      pin <= (ovr_en ? ovr_val : on) ^ strap_high;
  end
endmodule // pld_ind
`default_nettype wire

// file: hw/pld_top.v
// Purpose: Transceiver config, isolate, indicators, duplex, loopback, self-test
// Assumes: Management frames already decoded into register strobes
// Notes: Straps are sampled at the first edge after reset release
`timescale 1ns/10ps
`default_nettype none
`include "pld_map.vh"

// Functional notes
// RULE_01: Latch strapped address into control bits 4:0
// RULE_02: Strapped zero isolates; written zero does not
// RULE_03: Floating strap pins give address 00001
// RULE_04: Basic control bit 10 isolates
// RULE_05: Isolated: ignore transmit, float MII outputs
// RULE_06: Management access keeps working while isolated
// RULE_07: Isolated line sends only idles or pulses
// RULE_08: Link detection continues while isolated
// RULE_09: Indicator mode from control bits 6:5
// RULE_10: Link indicator steady, or blinking on activity
// RULE_11: Ten-meg link: seven pulses or packet
// RULE_12: Rate indicator on at 100 Mb/s
// RULE_13: Third indicator: activity, collision or duplex
// RULE_14: Indicator polarity opposite to strapped level
// RULE_15: Override register at 18h drives indicators
// RULE_16: Half duplex carrier sense on tx or rx
// RULE_17: Full duplex: no collision, carrier on rx
// RULE_18: Bit 14 loops tx to rx, status bit 3
// RULE_19: Software disables negotiation before loopback
// RULE_20: Self-test sequence 9 or 15 bits, compared
// RULE_21: Self-test status fails until good, latches errors
// RULE_22: Diag bit 5 continuous, bits 15:8 errors
// RULE_23: Phy status register at address 10h
module pld_top #(
  parameter LOSS_CYCLES = `PLD_LINK_LOSS_MS * 1000 * `PLD_CLK_MHZ,
  parameter BLINK_CYCLES = `PLD_BLINK_MS * 1000 * `PLD_CLK_MHZ
) (
  input wire SYS_CLK,
  input wire RST_B,
  input wire [4:0] STRAP_ADDR,
  input wire [4:0] STRAP_ADDR_FLOAT,
  input wire [2:0] STRAP_IND,
  input wire STRAP_CFG0,
  input wire [4:0] REG_ADDR,
  input wire [15:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [15:0] REG_RDATA,
  input wire [3:0] TXD,
  input wire TX_EN,
  output reg [3:0] RXD,
  output reg RX_DV,
  output reg RX_ER,
  output reg CRS,
  output reg COL,
  output reg MII_OE,
  input wire [3:0] LINE_RXD,
  input wire LINE_RX_DV,
  input wire LINE_RX_ER,
  input wire LINE_SD,
  input wire LINE_NLP,
  input wire LINE_PKT_OK,
  input wire AN_SPEED_100,
  input wire AN_FULL_DUPLEX,
  output reg [3:0] LINE_TXD,
  output reg LINE_TX_EN,
  output reg LINE_IDLE,
  output wire LINK_IND,
  output wire RATE_IND,
  output wire ACT_COL_IND
);
  localparam [31:0] LOSS_W = LOSS_CYCLES;
  localparam [31:0] BLINK_W = BLINK_CYCLES;

  reg strap_pend_q;
  reg [2:0] ind_pol_q;
  reg [15:0] basic_control_reg;
  reg [15:0] phy_control_reg;
  reg [15:0] indicator_override_reg;
  reg diag_cont_q;
  reg [7:0] err_cnt_q;
  reg self_test_engine_stat_q;
  reg self_test_engine_fail_q;
  reg [15:0] pkt_cnt_q;
  reg [2:0] nlp_cnt_q;
  reg link10_q;
  reg [31:0] loss_cnt_q;
  reg [31:0] blink_cnt_q;
  reg blink_q;
  reg self_test_engine_clr;
  reg [15:0] phy_status_reg;
  wire [4:0] mgmt_addr_strap;
  wire isolate;
  wire speed100;
  wire full_dup;
  wire loop_en;
  wire link_ok;
  wire [1:0] indicator_mode_select;
  wire ind_mode1;
  wire ind_mode3;
  wire tx_act;
  wire rx_act;
  wire activity;
  wire collision;
  wire self_test_engine;
  wire continuous_test_tx;
  wire self_test_engine_tx;
  wire [3:0] prbs_nib;
  wire prbs_good;
  wire prbs_err;
  wire [3:0] rx_nib;
  wire rx_val;

  ////////////////////////////////////////////////////////////////
  // Strap handling
  // Floating pins resolve to their weak pulls before capture
  assign mgmt_addr_strap = (STRAP_ADDR & ~STRAP_ADDR_FLOAT) |
                           (`PLD_ADDR_PULL & STRAP_ADDR_FLOAT); // RULE_03

  // Resolved operating mode
  assign speed100 = basic_control_reg[`PLD_BC_ANEN] ? AN_SPEED_100 :
                    basic_control_reg[`PLD_BC_SPEED];
  assign full_dup = basic_control_reg[`PLD_BC_ANEN] ? AN_FULL_DUPLEX :
                    basic_control_reg[`PLD_BC_DUPLEX];
  assign isolate = basic_control_reg[`PLD_BC_ISO]; // RULE_04
  assign loop_en = basic_control_reg[`PLD_BC_LOOP];
  assign self_test_engine = phy_control_reg[`PLD_PC_BSTART];
  assign continuous_test_tx = diag_cont_q;
  assign indicator_mode_select = phy_control_reg[`PLD_PC_CFG1:`PLD_PC_CFG0];
  assign ind_mode1 = indicator_mode_select[0]; // RULE_09
  assign ind_mode3 = indicator_mode_select == 2'b10; // RULE_09

  ////////////////////////////////////////////////////////////////
  // Management registers
  // Straps land one edge after reset release so no port feeds the reset
  // branch. Isolate from a zero strap sits in the basic control bit, so
  // software can leave it; writing zero to the address field never sets it.
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      strap_pend_q <= 1'b1;
      ind_pol_q <= 3'h0;
      basic_control_reg <= `PLD_BC_RESET;
      phy_control_reg <= 16'h0000;
      indicator_override_reg <= 16'h0000;
      diag_cont_q <= 1'b0;
    end else if (strap_pend_q) begin
      strap_pend_q <= 1'b0;
      ind_pol_q <= STRAP_IND; // RULE_14
      phy_control_reg[`PLD_PC_ADDR_HI:0] <= mgmt_addr_strap; // RULE_01
      phy_control_reg[`PLD_PC_CFG0] <= STRAP_CFG0;
      basic_control_reg[`PLD_BC_ISO] <= mgmt_addr_strap == 5'h00; // RULE_02
    end else if (REG_WR) begin
      // Decoding stays live in isolate mode
      if (REG_ADDR == `PLD_OFF_BASIC) begin // RULE_06
        basic_control_reg <= REG_WDATA;
      end else if (REG_ADDR == `PLD_OFF_IND) begin
        indicator_override_reg <= REG_WDATA; // RULE_15
      end else if (REG_ADDR == `PLD_OFF_PHYCTL) begin
        phy_control_reg <= REG_WDATA & ~(16'h0001 << `PLD_PC_BSTAT); // RULE_02
      end else if (REG_ADDR == `PLD_OFF_DIAG) begin
        diag_cont_q <= REG_WDATA[`PLD_DG_CONT]; // RULE_22
      end
    end
  end

  // Any write to the control register restarts the checker status
  always @* begin
    self_test_engine_clr = REG_WR & ~strap_pend_q & (REG_ADDR == `PLD_OFF_PHYCTL);
  end

  // Status word; the table holds offset 10h
  always @* begin
    phy_status_reg = 16'h0000; // RULE_23
    phy_status_reg[`PLD_ST_LINK] = link_ok;
    phy_status_reg[`PLD_ST_SPEED10] = ~speed100;
    phy_status_reg[`PLD_ST_DUPLEX] = full_dup;
    phy_status_reg[`PLD_ST_LOOP] = loop_en; // RULE_18
  end

  // Read answer one cycle after the strobe; unmapped reads give zero.
  // The override register returns its contents, never the pin levels.
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B)
      REG_RDATA <= 16'h0000;
    else if (REG_RD) begin
      if (REG_ADDR == `PLD_OFF_BASIC)
        REG_RDATA <= basic_control_reg;
      else if (REG_ADDR == `PLD_OFF_STATUS)
        REG_RDATA <= phy_status_reg; // RULE_23
      else if (REG_ADDR == `PLD_OFF_IND)
        REG_RDATA <= indicator_override_reg; // RULE_15
      else if (REG_ADDR == `PLD_OFF_PHYCTL)
        REG_RDATA <= {phy_control_reg[15:9], self_test_engine_stat_q, phy_control_reg[7:0]};
      else if (REG_ADDR == `PLD_OFF_DIAG)
        REG_RDATA <= {err_cnt_q, 2'b00, diag_cont_q, 5'h00}; // RULE_22
      else
        REG_RDATA <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Link detection, independent of isolate
  // Pulse count restarts whenever the loss timer runs out
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      nlp_cnt_q <= 3'h0;
      link10_q <= 1'b0;
      loss_cnt_q <= 32'h00000000;
    end else if (LINE_NLP || LINE_PKT_OK) begin
      loss_cnt_q <= 32'h00000000;
      if (nlp_cnt_q != `PLD_NLP_MIN)
        nlp_cnt_q <= nlp_cnt_q + 3'h1;
      if (LINE_PKT_OK || nlp_cnt_q == `PLD_NLP_MIN - 3'h1)
        link10_q <= 1'b1; // RULE_11
    end else if (loss_cnt_q == LOSS_W - 32'h1) begin
      loss_cnt_q <= 32'h00000000;
      nlp_cnt_q <= 3'h0;
      link10_q <= 1'b0; // RULE_11
    end else begin
      loss_cnt_q <= loss_cnt_q + 32'h1;
    end
  end

  assign link_ok = speed100 ? LINE_SD : link10_q; // RULE_08

  ////////////////////////////////////////////////////////////////
  // Datapath: isolate, loopback, duplex
  assign tx_act = TX_EN & ~isolate; // RULE_05
  assign rx_act = loop_en ? tx_act : LINE_RX_DV;
  assign activity = tx_act | LINE_RX_DV;
  assign collision = ~full_dup & ~loop_en & tx_act & LINE_RX_DV; // RULE_17

  // MII receive side is registered; loopback feeds transmit nibbles back
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RXD <= 4'h0;
      RX_DV <= 1'b0;
      RX_ER <= 1'b0;
      CRS <= 1'b0;
      COL <= 1'b0;
      MII_OE <= 1'b0;
    end else begin
      MII_OE <= ~isolate & ~strap_pend_q; // RULE_05
      RXD <= loop_en ? TXD : LINE_RXD; // RULE_18
      RX_DV <= rx_act;
      RX_ER <= loop_en ? 1'b0 : LINE_RX_ER;
      CRS <= full_dup ? rx_act : (rx_act | tx_act); // RULE_16 RULE_17
      COL <= collision; // RULE_17
    end
  end

  // Self-test packet framing; one packet unless continuous
  assign self_test_engine_tx = self_test_engine & (continuous_test_tx || pkt_cnt_q != 16'h0000);

  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B)
      pkt_cnt_q <= 16'h0000;
    else if (self_test_engine_clr)
      pkt_cnt_q <= `PLD_SELF_TEST_ENGINE_PKT;
    else if (self_test_engine_tx && pkt_cnt_q != 16'h0000)
      pkt_cnt_q <= pkt_cnt_q - 16'h1; // RULE_22
  end

  // Line transmit: isolate keeps all data off the wire and loopback keeps MAC data off, but both
  // leave idles or link pulses running
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      LINE_TXD <= 4'h0;
      LINE_TX_EN <= 1'b0;
      LINE_IDLE <= 1'b0;
    end else begin
      if (self_test_engine_tx && !isolate) begin
        LINE_TXD <= prbs_nib; // RULE_20
        LINE_TX_EN <= 1'b1;
      end else begin
        LINE_TXD <= TXD;
        LINE_TX_EN <= tx_act & ~loop_en; // RULE_07 RULE_18
      end
      LINE_IDLE <= ~(self_test_engine_tx && !isolate) & ~(tx_act & ~loop_en); // RULE_07
    end
  end

  ////////////////////////////////////////////////////////////////
  // Self-test engine
  assign rx_nib = loop_en ? prbs_nib : LINE_RXD;
  assign rx_val = self_test_engine & (loop_en ? self_test_engine_tx : LINE_RX_DV);

  pld_prbs u_prbs (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .len15(phy_control_reg[`PLD_PC_PRBS15]),
    .clear(self_test_engine_clr),
    .gen_adv(self_test_engine_tx),
    .chk_valid(rx_val),
    .chk_data(rx_nib),
    .gen_data(prbs_nib),
    .good(prbs_good),
    .err(prbs_err)
  ); // RULE_20

  // An error in the clearing cycle still latches fail and counts
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      self_test_engine_stat_q <= 1'b0;
      self_test_engine_fail_q <= 1'b0;
      err_cnt_q <= 8'h00;
    end else begin
      if (prbs_err) begin
        self_test_engine_fail_q <= 1'b1; // RULE_21
        self_test_engine_stat_q <= 1'b0;
      end else if (self_test_engine_clr) begin
        self_test_engine_fail_q <= 1'b0;
        self_test_engine_stat_q <= 1'b0;
      end else if (prbs_good && !self_test_engine_fail_q) begin
        self_test_engine_stat_q <= 1'b1; // RULE_21
      end
      if (prbs_err && (self_test_engine_clr || err_cnt_q != 8'hFF))
        err_cnt_q <= (self_test_engine_clr ? 8'h00 : err_cnt_q) + 8'h01; // RULE_22
      else if (self_test_engine_clr)
        err_cnt_q <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Indicators
  // Blink rate from a cycle divider; the enable pulse toggles the phase
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      blink_cnt_q <= 32'h00000000;
      blink_q <= 1'b0;
    end else if (blink_cnt_q == BLINK_W - 32'h1) begin
      blink_cnt_q <= 32'h00000000;
      blink_q <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
    end
  end

  pld_ind u_link (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .on(link_ok & (ind_mode1 | ~(activity & blink_q))), // RULE_10
    .ovr_en(indicator_override_reg[`PLD_IO_EN_LO]),
    .ovr_val(indicator_override_reg[`PLD_IO_VAL_LO]), // RULE_15
    .strap_high(ind_pol_q[0]), // RULE_14
    .pin(LINK_IND)
  );

  pld_ind u_rate (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .on(speed100), // RULE_12
    .ovr_en(indicator_override_reg[`PLD_IO_EN_LO + 1]),
    .ovr_val(indicator_override_reg[`PLD_IO_VAL_LO + 1]),
    .strap_high(ind_pol_q[1]),
    .pin(RATE_IND)
  );

  pld_ind u_actcol (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .on(ind_mode1 ? activity : (ind_mode3 ? full_dup : collision)), // RULE_13
    .ovr_en(indicator_override_reg[`PLD_IO_EN_LO + 2]),
    .ovr_val(indicator_override_reg[`PLD_IO_VAL_LO + 2]),
    .strap_high(ind_pol_q[2]),
    .pin(ACT_COL_IND)
  );
endmodule // pld_top
`default_nettype wire

// file: testbench/pld_top_monitor.sv
// Purpose: Port-level checker for pld_top
// Assumes: Straps held steady outside reset, writes never on the first edge
// Notes: Mirrors written registers to predict the outputs
`timescale 1ns/10ps
`default_nettype none
module pld_monitor (
  input wire SYS_CLK,
  input wire RST_B,
  input wire [2:0] STRAP_IND,
  input wire [4:0] REG_ADDR,
  input wire [15:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  input wire [15:0] REG_RDATA,
  input wire [3:0] TXD,
  input wire TX_EN,
  input wire [3:0] RXD,
  input wire RX_DV,
  input wire CRS,
  input wire COL,
  input wire MII_OE,
  input wire LINE_RX_DV,
  input wire AN_SPEED_100,
  input wire AN_FULL_DUPLEX,
  input wire LINE_TX_EN,
  input wire RATE_IND,
  input wire ACT_COL_IND
);
  ////////////////////////////////////////
  reg [15:0] bc_q;
  reg [15:0] pc_q;
  reg [15:0] ov_q;
  reg dg_q;
  reg pv_q;
  reg [1:0] up_q;
  wire full = bc_q[12] ? AN_FULL_DUPLEX : bc_q[8];
  wire spd = bc_q[12] ? AN_SPEED_100 : bc_q[13];
  wire lp = bc_q[14];
  wire ok = up_q == 2'h3;
  wire nl = ok && MII_OE && !lp;
  wire stop = !pc_q[9];
  wire m3 = pv_q && pc_q[6:5] == 2'h2 && !ov_q[2];
  wire tx_or = TX_EN || LINE_RX_DV;
  wire tx_and = TX_EN && LINE_RX_DV;
  // Shadow copies; ok holds off checks until straps and outputs have settled
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      bc_q <= 16'h1000;
      pc_q <= 16'h0000;
      ov_q <= 16'h0000;
      dg_q <= 1'b0;
      pv_q <= 1'b0;
      up_q <= 2'h0;
    end else begin
      up_q <= ok ? up_q : up_q + 2'h1;
      if (REG_WR && REG_ADDR == 5'h00) bc_q <= REG_WDATA;
      if (REG_WR && REG_ADDR == 5'h19) pc_q <= REG_WDATA;
      if (REG_WR && REG_ADDR == 5'h19) pv_q <= 1'b1;
      if (REG_WR && REG_ADDR == 5'h18) ov_q <= REG_WDATA;
      if (REG_WR && REG_ADDR == 5'h1B) dg_q <= REG_WDATA[5];
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  property p_crs_half; nl && $past(nl) && !$past(full) |-> CRS == $past(tx_or) && COL == $past(tx_and); endproperty
  a_crs_half: assert property (p_crs_half) else $error("half duplex carrier or collision wrong");
  property p_full; nl && $past(nl) && $past(full) |-> !COL && CRS == $past(LINE_RX_DV); endproperty
  a_full: assert property (p_full) else $error("full duplex carrier or collision wrong");
  property p_loop; ok && MII_OE && lp && $past(lp) && stop && $past(stop) |-> RXD == $past(TXD) && RX_DV == $past(TX_EN) && !LINE_TX_EN; endproperty
  a_loop: assert property (p_loop) else $error("loopback path wrong");
  property p_iso; ok && bc_q[10] && $past(bc_q[10]) |-> !MII_OE && !LINE_TX_EN; endproperty
  a_iso: assert property (p_iso) else $error("isolate not honoured");
  property p_rate; ok && !ov_q[1] && !$past(ov_q[1]) && $past(spd) == $past(spd, 2) |-> RATE_IND == ($past(spd) ^ STRAP_IND[1]); endproperty
  a_rate: assert property (p_rate) else $error("rate indicator wrong");
  property p_mode3; ok && m3 && $past(m3) && $past(full) == $past(full, 2) |-> ACT_COL_IND == ($past(full) ^ STRAP_IND[2]); endproperty
  a_mode3: assert property (p_mode3) else $error("duplex indicator wrong");
  property p_stat; ok && REG_RD && REG_ADDR == 5'h10 |=> REG_RDATA[3] == $past(lp); endproperty
  a_stat: assert property (p_stat) else $error("loopback status wrong");
  property p_diag; ok && REG_RD && REG_ADDR == 5'h1B |=> REG_RDATA[5] == $past(dg_q); endproperty
  a_diag: assert property (p_diag) else $error("continuous bit readback wrong");
endmodule // pld_monitor
bind pld_top pld_monitor u_pld_monitor (
  .SYS_CLK(SYS_CLK), .RST_B(RST_B), .STRAP_IND(STRAP_IND), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .TXD(TXD), .TX_EN(TX_EN), .RXD(RXD), .RX_DV(RX_DV), .CRS(CRS), .COL(COL),
  .MII_OE(MII_OE), .LINE_RX_DV(LINE_RX_DV), .AN_SPEED_100(AN_SPEED_100),
  .AN_FULL_DUPLEX(AN_FULL_DUPLEX), .LINE_TX_EN(LINE_TX_EN), .RATE_IND(RATE_IND),
  .ACT_COL_IND(ACT_COL_IND)
);
`default_nettype wire

// file: testbench/pld_mac_model.sv
// Purpose: MAC transmit side facing the MII
// Assumes: One nibble per clock while send is high
// Notes: Idle data toggles so stale nibbles are never mistaken for frames
`timescale 1ns/10ps
`default_nettype none
module pld_mac_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic send,
  output logic [3:0] txd,
  output logic tx_en
);
  ////////////////////////////////////////
  // Counting payload makes looped data traceable
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txd <= 4'h0;
      tx_en <= 1'b0;
    end else begin
      tx_en <= send;
      txd <= send ? txd + 4'h1 : ~txd;
    end
  end
endmodule // pld_mac_model
`default_nettype wire

// file: testbench/pld_top_tb.sv
// Purpose: Self-checking bench for pld_top
// Assumes: Short loss and blink counts via parameters
// Notes: Straps first, then duplex table, indicators, loopback, self-test, isolate
`timescale 1ns/10ps
`default_nettype none
module pld_top_tb;
  ////////////////////////////////////////
  logic sys_clk, rst_b, reg_wr, reg_rd, send, an_full, an_spd, line_rx_dv, line_nlp;
  logic [4:0] strap_addr, strap_flt, reg_addr;
  logic line_sd, line_pkt_ok, rx_er;
  logic [2:0] strap_ind;
  logic [15:0] reg_wdata, reg_rdata;
  logic [3:0] rxd, txd, line_txd;
  logic tx_en, rx_dv, crs, col, mii_oe, line_tx_en, line_idle, link_ind, rate_ind, act_col_ind;
  int error_cnt, n_tests, cyc;
  // Rows: basic control, negotiated full, tx, rx, expected carrier, collision
  logic [20:0] rows [7] = '{{16'h0000, 5'b01010}, {16'h0000, 5'b01111},
    {16'h0000, 5'b00110}, {16'h0100, 5'b01000}, {16'h0100, 5'b01110},
    {16'h1000, 5'b11110}, {16'h1000, 5'b01111}};
  pld_top #(.LOSS_CYCLES(64), .BLINK_CYCLES(8)) u_pld_top (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .STRAP_ADDR(strap_addr), .STRAP_ADDR_FLOAT(strap_flt),
    .STRAP_IND(strap_ind), .STRAP_CFG0(1'b0), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .TXD(txd), .TX_EN(tx_en),
    .RXD(rxd), .RX_DV(rx_dv), .RX_ER(rx_er), .CRS(crs), .COL(col), .MII_OE(mii_oe),
    .LINE_RXD(4'h0), .LINE_RX_DV(line_rx_dv), .LINE_RX_ER(line_rx_dv), .LINE_SD(line_sd),
    .LINE_NLP(line_nlp), .LINE_PKT_OK(line_pkt_ok), .AN_SPEED_100(an_spd),
    .AN_FULL_DUPLEX(an_full), .LINE_TXD(line_txd), .LINE_TX_EN(line_tx_en),
    .LINE_IDLE(line_idle), .LINK_IND(link_ind), .RATE_IND(rate_ind), .ACT_COL_IND(act_col_ind));
  pld_mac_model u_pld_mac_model (.clk(sys_clk), .rst_b(rst_b), .send(send), .txd(txd),
    .tx_en(tx_en));
  always #5 sys_clk = ~sys_clk;
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard, far above the expected nine hundred or so cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run;
    end
  end
  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rst(input logic [4:0] a, input logic [4:0] f, input logic [2:0] i);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    strap_addr <= a;
    strap_flt <= f;
    strap_ind <= i;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands until the next read, so one spare edge is safe
  task automatic rd(input logic [4:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    tk(1);
  endtask
  initial begin
    {sys_clk, rst_b, reg_wr, reg_rd, send, an_full, an_spd, line_rx_dv, line_nlp} = 9'h000;
    {line_sd, line_pkt_ok} = 2'h0;
    {strap_addr, strap_flt, reg_addr, strap_ind, reg_wdata} = 34'h0;
    {error_cnt, n_tests, cyc} = 0;
    rst(5'h00, 5'h00, 3'h0);
    rd(5'h00); chk("iso_strap", 16'(reg_rdata[10]), 16'h1);
    chk("oe_strap", 16'(mii_oe), 16'h0);
    rd(5'h19); chk("adr_zero", 16'(reg_rdata[4:0]), 16'h0);
    rst(5'h00, 5'h1F, 3'h7);
    rd(5'h19); chk("adr_pull", 16'(reg_rdata[4:0]), 16'h1);
    chk("rate_pol", 16'(rate_ind), 16'h1);
    rst(5'h0A, 5'h00, 3'h0);
    rd(5'h19); chk("adr_strap", 16'(reg_rdata[4:0]), 16'h0A);
    chk("self_test_engine_rst", 16'(reg_rdata[8]), 16'h0);
    wr(5'h19, 16'h0000); tk(3); chk("oe_wr0", 16'(mii_oe), 16'h1);
    foreach (rows[k]) begin
      wr(5'h00, rows[k][20:5]);
      {an_full, send, line_rx_dv} <= rows[k][4:2];
      tk(3);
      chk("crs", 16'(crs), 16'(rows[k][1]));
      chk("col", 16'(col), 16'(rows[k][0]));
      chk("rx_er", 16'(rx_er), 16'(rows[k][2]));
      chk("ltx_en", 16'(line_tx_en), 16'(rows[k][3]));
    end
    {send, line_rx_dv} <= 2'b00;
    wr(5'h00, 16'h2100); wr(5'h19, 16'h004A); tk(3);
    chk("rate100", 16'(rate_ind), 16'h1);
    chk("fdx_ind", 16'(act_col_ind), 16'h1);
    wr(5'h00, 16'h0000); tk(3); chk("hdx_ind", 16'(act_col_ind), 16'h0);
    chk("rate10", 16'(rate_ind), 16'h0);
    an_spd <= 1'b1;
    wr(5'h00, 16'h1000); tk(3); chk("rate_an", 16'(rate_ind), 16'h1);
    wr(5'h18, 16'h0007); tk(3);
    chk("ovr_off", 16'({link_ind, rate_ind, act_col_ind}), 16'h0000);
    wr(5'h18, 16'h003F); tk(3);
    chk("ovr_pins", 16'({link_ind, rate_ind, act_col_ind}), 16'h0007);
    rd(5'h18); chk("ovr_read", reg_rdata, 16'h003F);
    wr(5'h18, 16'h0000);
    wr(5'h00, 16'h0000);
    wr(5'h00, 16'h4000); {send, line_rx_dv} <= 2'b11; tk(3);
    chk("lp_dv", 16'(rx_dv), 16'h1);
    chk("lp_line", 16'(line_tx_en), 16'h0);
    chk("lp_er", 16'(rx_er), 16'h0);
    rd(5'h10); chk("lp_stat", 16'(reg_rdata[3]), 16'h1);
    {send, line_rx_dv} <= 2'b00;
    wr(5'h1B, 16'h0020);
    for (int i = 0; i < 2; i++) begin
      wr(5'h19, i[0] ? 16'h060A : 16'h020A); tk(300);
      rd(5'h19); chk("self_test_engine_ok", 16'(reg_rdata[8]), 16'h1);
      rd(5'h1B); chk("self_test_engine_err", 16'(reg_rdata[15:8]), 16'h0);
    end
    chk("self_test_engine_cont", 16'(reg_rdata[5]), 16'h1);
    wr(5'h19, 16'h000A);
    wr(5'h00, 16'h0400); send <= 1'b1; tk(3);
    chk("iso_oe", 16'(mii_oe), 16'h0);
    chk("iso_line", 16'({line_idle, line_tx_en}), 16'h2);
    for (int i = 1; i <= 7; i++) begin
      line_nlp <= 1'b1; @(posedge sys_clk); line_nlp <= 1'b0; tk(3);
      if (i >= 6) begin
        rd(5'h10); chk("link", 16'(reg_rdata[0]), 16'(i == 7));
      end
    end
    rd(5'h19); chk("iso_mgmt", 16'(reg_rdata[4:0]), 16'h0A);
    tk(80); rd(5'h10); chk("link_loss", 16'(reg_rdata[0]), 16'h0);
    line_pkt_ok <= 1'b1; @(posedge sys_clk); line_pkt_ok <= 1'b0; tk(1);
    rd(5'h10); chk("link_pkt", 16'(reg_rdata[0]), 16'h1);
    {line_sd, line_rx_dv} <= 2'b11;
    wr(5'h00, 16'h2400); wr(5'h19, 16'h002A); tk(3);
    rd(5'h10); chk("link100", 16'(reg_rdata[0]), 16'h1);
    chk("link_ind", 16'(link_ind), 16'h1);
    chk("act_ind", 16'(act_col_ind), 16'h1);
    complete_run;
  end
endmodule // pld_top_tb
`default_nettype wire
